// ===== logic/abc_axil.sv
// AXI4-Lite slave front end producing single-cycle register strobes
`timescale 1ns/1ps
module abc_axil (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             wr_stb,
    output logic [3:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    output logic             rd_stb,
    output logic [3:0]       rd_addr
);
    typedef struct packed {
        logic        aw_have;
        logic        w_have;
        logic [3:0]  aw;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic        bv;
        logic        rv;
        logic        aw_rdy;   // Registered readies, high when free
        logic        w_rdy;
        logic        ar_rdy;
    } abc_bus_state_t;

    abc_bus_state_t st;
    abc_bus_state_t next_st;

    // Address and data captured in either order, write fires once both held
    always_comb begin
        next_st = st;
        if (awvalid && awready) begin
            next_st.aw_have = 1'b1;
            next_st.aw      = awaddr;
        end
        if (wvalid && wready) begin
            next_st.w_have = 1'b1;
            next_st.wd     = wdata;
            next_st.ws     = wstrb;
        end
        if (st.aw_have && st.w_have) begin
            next_st.aw_have = 1'b0;
            next_st.w_have  = 1'b0;
            next_st.bv      = 1'b1;
        end
        if (st.bv && bready) begin
            next_st.bv = 1'b0;
        end
        if (arvalid && arready) begin
            next_st.rv = 1'b1;
        end else if (st.rv && rready) begin
            next_st.rv = 1'b0;
        end
        // Readies kept as flops so the top ports come straight from registers
        next_st.aw_rdy = !next_st.aw_have && !next_st.bv;
        next_st.w_rdy  = !next_st.w_have && !next_st.bv;
        next_st.ar_rdy = !next_st.rv;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st        <= '0;
            st.aw_rdy <= 1'b1;
            st.w_rdy  <= 1'b1;
            st.ar_rdy <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign awready = st.aw_rdy;
    assign wready  = st.w_rdy;
    assign bvalid  = st.bv;
    assign arready = st.ar_rdy;
    assign rvalid  = st.rv;
    assign wr_stb  = st.aw_have && st.w_have;
    assign wr_addr = st.aw;
    assign wr_data = st.wd;
    assign wr_strb = st.ws;
    assign rd_stb  = arvalid && arready;
    assign rd_addr = araddr;
endmodule

// ===== logic/abc_match.sv
// Combinational break condition matcher
`timescale 1ns/1ps
module abc_match (
    input  wire abc_pkg::abc_cycle_t cyc,
    input  wire abc_pkg::abc_cfg_t   cfg,
    output logic                     hit
);
    // Mask of compared upper address bits; 1XX treated as full compare
    function automatic logic [15:0] addr_mask(input logic [2:0] sel);
        unique case (sel)
            3'b001:  addr_mask = 16'hFFF0;
            3'b010:  addr_mask = 16'hFF00;
            3'b011:  addr_mask = 16'hF000;
            default: addr_mask = 16'hFFFF;
        endcase
    endfunction

    logic [1:0]  csel;
    logic [1:0]  dcmp;
    logic        type_ok;
    logic        addr_ok;
    logic        data_ok;
    logic        upper_lane;

    // Break condition evaluated on one cycle only
    always_comb begin
        csel = cfg.control[abc_pkg::CTL_CSEL_LSB +: 2];
        dcmp = cfg.control[abc_pkg::CTL_DCMP_LSB +: 2];
        unique case (abc_pkg::abc_csel_t'(csel))
            abc_pkg::CSEL_FETCH: type_ok = cyc.fetch;
            abc_pkg::CSEL_READ:  type_ok = !cyc.fetch && !cyc.write;
            abc_pkg::CSEL_WRITE: type_ok = !cyc.fetch && cyc.write;
            abc_pkg::CSEL_RW:    type_ok = !cyc.fetch;
        endcase
        addr_ok = ((cyc.addr ^ cfg.brk_addr)
                   & addr_mask(cfg.control[abc_pkg::CTL_ACMP_LSB +: 3])) == 16'h0000;
        // Bytes and 8-bit register space use upper lane; io8 words arrive split
        upper_lane = !cyc.word || cyc.io8 || !cyc.addr[0];
        // Lane compare against high or low break byte
        unique case (abc_pkg::abc_dcmp_t'(dcmp))
            abc_pkg::DCMP_NONE: data_ok = 1'b1;
            abc_pkg::DCMP_LOW:  data_ok = !upper_lane
                                && cyc.data[7:0] == cfg.brk_data[7:0];
            abc_pkg::DCMP_HIGH: data_ok = upper_lane
                                && cyc.data[15:8] == cfg.brk_data[15:8];
            abc_pkg::DCMP_FULL: data_ok = cyc.data == cfg.brk_data;
        endcase
        hit = cyc.valid && type_ok && addr_ok && data_ok;
    end
endmodule

// ===== logic/abc_pkg.sv
// Package of constants and carrier types for the address break comparator
// ==========================================================================
package abc_pkg;

    // ======================================================================
    // Register map (one aligned word each)
    localparam logic [3:0]  ADDR_CONTROL  = 4'h0;
    localparam logic [3:0]  ADDR_STATUS   = 4'h4;
    localparam logic [3:0]  ADDR_BRK_ADDR = 4'h8;
    localparam logic [3:0]  ADDR_BRK_DATA = 4'hC;

    // ======================================================================
    // Field positions and reset values
    localparam int          CTL_POST_RET  = 7;
    localparam int          CTL_CSEL_LSB  = 5;
    localparam int          CTL_ACMP_LSB  = 2;
    localparam int          CTL_DCMP_LSB  = 0;
    localparam int          STS_FLAG      = 7;
    localparam int          STS_ENABLE    = 6;
    localparam logic [7:0]  CONTROL_RESET = 8'h80;
    localparam logic [5:0]  STS_RSVD_VAL  = 6'h3F;
    localparam logic [15:0] BRK_ADDR_RST  = 16'hFFFF;
    localparam logic [15:0] BRK_DATA_INIT = 16'h0000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ======================================================================
    // Encodings
    typedef enum logic [1:0] {
        CSEL_FETCH = 2'b00,
        CSEL_READ  = 2'b01,
        CSEL_WRITE = 2'b10,
        CSEL_RW    = 2'b11
    } abc_csel_t;

    typedef enum logic [1:0] {
        DCMP_NONE = 2'b00,
        DCMP_LOW  = 2'b01,
        DCMP_HIGH = 2'b10,
        DCMP_FULL = 2'b11
    } abc_dcmp_t;

    // ======================================================================
    // One CPU bus cycle as seen by the comparator
    typedef struct packed {
        logic        valid;    // Cycle completes this clock
        logic        fetch;    // Instruction execution cycle
        logic        write;    // Data write (else read)
        logic        word;     // Word access
        logic        io8;      // Target is 8-bit register space
        logic [15:0] addr;
        logic [15:0] data;
    } abc_cycle_t;

    typedef struct packed {
        logic [7:0]  control;
        logic [15:0] brk_addr;
        logic [15:0] brk_data;
    } abc_cfg_t;

endpackage

// ===== logic/abc_top.sv
// Address break comparator: registers, flag logic and return masking
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module abc_top (
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    // AXI4-Lite register port
    input  wire logic [3:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [3:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // CPU core buses (same clock)
    input  wire logic        CPU_CYC_VALID,
    input  wire logic        CPU_CYC_FETCH,
    input  wire logic        CPU_CYC_WRITE,
    input  wire logic        CPU_CYC_WORD,
    input  wire logic        CPU_CYC_IO8,
    input  wire logic [15:0] CPU_ADDR,
    input  wire logic [15:0] CPU_DATA,
    input  wire logic        CPU_RETURN_DONE,
    input  wire logic        CPU_INSN_DONE,
    // Requests to the CPU
    output logic             BREAK_IRQ,
    output logic             POST_RETURN_MASK
);
    // ======================================================================
    // State
    typedef struct packed {
        logic [7:0]  control;
        logic [15:0] brk_addr;
        logic [15:0] brk_data;
        logic        flag;
        logic        enable;
        logic        flag_seen;   // Flag read as one since last clear
        logic        irq;
        logic        ret_mask;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  bresp;
    } abc_state_t;

    abc_state_t st;
    abc_state_t next_st;

    logic        wr_stb;
    logic [3:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        rd_stb;
    logic [3:0]  rd_addr;
    logic        hit;
    abc_pkg::abc_cycle_t cyc;
    abc_pkg::abc_cfg_t   cfg;

    // ======================================================================
    // Bus front end
    abc_axil u_axil (
        .clk     (REF_CLK),
        .rst_n   (RSTN),
        .awaddr  (S_AXI_AWADDR),
        .awvalid (S_AXI_AWVALID),
        .awready (S_AXI_AWREADY),
        .wdata   (S_AXI_WDATA),
        .wstrb   (S_AXI_WSTRB),
        .wvalid  (S_AXI_WVALID),
        .wready  (S_AXI_WREADY),
        .bvalid  (S_AXI_BVALID),
        .bready  (S_AXI_BREADY),
        .araddr  (S_AXI_ARADDR),
        .arvalid (S_AXI_ARVALID),
        .arready (S_AXI_ARREADY),
        .rvalid  (S_AXI_RVALID),
        .rready  (S_AXI_RREADY),
        .wr_stb  (wr_stb),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .rd_stb  (rd_stb),
        .rd_addr (rd_addr)
    );

    // ======================================================================
    // Comparator
    assign cyc = '{valid: CPU_CYC_VALID, fetch: CPU_CYC_FETCH, write: CPU_CYC_WRITE,
                   word: CPU_CYC_WORD, io8: CPU_CYC_IO8, addr: CPU_ADDR, data: CPU_DATA};
    assign cfg = '{control: st.control, brk_addr: st.brk_addr, brk_data: st.brk_data};

    abc_match u_match (
        .cyc (cyc),
        .cfg (cfg),
        .hit (hit)
    );

    // Status byte with reserved bits tied high
    function automatic logic [7:0] status_byte(input logic flag, input logic en);
        status_byte = {flag, en, abc_pkg::STS_RSVD_VAL};
    endfunction

    function automatic logic addr_known(input logic [3:0] a);
        addr_known = a == abc_pkg::ADDR_CONTROL || a == abc_pkg::ADDR_STATUS
                     || a == abc_pkg::ADDR_BRK_ADDR || a == abc_pkg::ADDR_BRK_DATA;
    endfunction

    // ======================================================================
    // Next state
    always_comb begin
        next_st = st;
        // Register reads; reading flag as one arms the clear
        if (rd_stb) begin
            next_st.rresp = addr_known(rd_addr) ? abc_pkg::RESP_OKAY
                                                : abc_pkg::RESP_SLVERR;
            unique case (rd_addr)
                abc_pkg::ADDR_CONTROL:  next_st.rdata = {24'h000000, st.control};
                abc_pkg::ADDR_STATUS: begin
                    next_st.rdata = {24'h000000, status_byte(st.flag, st.enable)};
                    if (st.flag) begin
                        next_st.flag_seen = 1'b1;
                    end
                end
                abc_pkg::ADDR_BRK_ADDR: next_st.rdata = {16'h0000, st.brk_addr};
                abc_pkg::ADDR_BRK_DATA: next_st.rdata = {16'h0000, st.brk_data};
                default:                next_st.rdata = 32'h00000000;
            endcase
        end
        // Register writes, byte lanes honoured for the 16-bit registers
        if (wr_stb) begin
            next_st.bresp = addr_known(wr_addr) ? abc_pkg::RESP_OKAY
                                                : abc_pkg::RESP_SLVERR;
            unique case (wr_addr)
                abc_pkg::ADDR_CONTROL: begin
                    if (wr_strb[0]) begin
                        next_st.control = wr_data[7:0];
                    end
                end
                abc_pkg::ADDR_STATUS: begin
                    if (wr_strb[0]) begin
                        next_st.enable = wr_data[abc_pkg::STS_ENABLE];
                        // Zero write clears only after a read of one
                        if (!wr_data[abc_pkg::STS_FLAG] && st.flag_seen) begin
                            next_st.flag      = 1'b0;
                            next_st.flag_seen = 1'b0;
                        end
                    end
                end
                abc_pkg::ADDR_BRK_ADDR: begin
                    if (wr_strb[0]) begin
                        next_st.brk_addr[7:0] = wr_data[7:0];
                    end
                    if (wr_strb[1]) begin
                        next_st.brk_addr[15:8] = wr_data[15:8];
                    end
                end
                abc_pkg::ADDR_BRK_DATA: begin
                    if (wr_strb[0]) begin
                        next_st.brk_data[7:0] = wr_data[7:0];
                    end
                    if (wr_strb[1]) begin
                        next_st.brk_data[15:8] = wr_data[15:8];
                    end
                end
                default: begin
                end
            endcase
        end
        // Hardware set wins over a same-cycle clear
        if (hit) begin
            next_st.flag = 1'b1;
        end
        // Request ignores the CPU global mask; CPU takes it at insn end
        next_st.irq = next_st.flag && next_st.enable;
        // Mask after return until one more instruction retires
        if (CPU_RETURN_DONE && !st.control[abc_pkg::CTL_POST_RET]) begin
            next_st.ret_mask = 1'b1;
        end else if (CPU_INSN_DONE) begin
            next_st.ret_mask = 1'b0;
        end
    end

    // ======================================================================
    // Registers; break data reset value is don't-care, zero keeps it known
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st          <= '0;
            st.control  <= abc_pkg::CONTROL_RESET;
            st.brk_addr <= abc_pkg::BRK_ADDR_RST;
            st.brk_data <= abc_pkg::BRK_DATA_INIT;
        end else begin
            st <= next_st;
        end
    end

    // ======================================================================
    // Outputs
    assign S_AXI_BRESP      = st.bresp;
    assign S_AXI_RDATA      = st.rdata;
    assign S_AXI_RRESP      = st.rresp;
    assign BREAK_IRQ        = st.irq;
    assign POST_RETURN_MASK = st.ret_mask;
endmodule

// ===== verif/abc_cpu.sv
// CPU core stand-in driving bus cycles and retirement pulses
`timescale 1ns/1ps
module abc_cpu (
    input  wire logic           clk,
    output abc_pkg::abc_cycle_t cyc,
    output logic                ret_done,
    output logic                insn_done
);
    // Quiet buses at time zero
    initial begin
        cyc = '0;
        {ret_done, insn_done} = 2'h0;
    end

    // One completed cycle; released buses flip so stale values never match by luck
    task automatic pulse(input abc_pkg::abc_cycle_t c);
        @(posedge clk);
        cyc <= c;
        @(posedge clk);
        c.valid = 1'b0;
        c.addr  = ~c.addr;
        c.data  = ~c.data;
        cyc <= c;
    endtask

    // Words to 8-bit space go out as two byte cycles, high byte first at the address the bench hands over
    task automatic access(input abc_pkg::abc_cycle_t c);
        abc_pkg::abc_cycle_t b;
        b = c;
        if (c.word && c.io8) begin
            b.word = 1'b0;
            b.data = {c.data[15:8], ~c.data[15:8]};
            pulse(b);
            b.addr = c.addr + 16'h0001;
            b.data = {c.data[7:0], ~c.data[7:0]};
        end
        pulse(b);
    endtask

    // Retirement of a return (1) or of any other instruction (0)
    task automatic retire(input logic is_ret);
        @(posedge clk);
        ret_done  <= is_ret;
        insn_done <= !is_ret;
        @(posedge clk);
        {ret_done, insn_done} <= 2'h0;
    endtask
endmodule

// ===== verif/abc_props.sv
// Port-level assertions for the address break comparator
`timescale 1ns/1ps
module abc_props (
    input wire logic        REF_CLK,
    input wire logic        RSTN,
    input wire logic [3:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        CPU_CYC_VALID,
    input wire logic        CPU_RETURN_DONE,
    input wire logic        CPU_INSN_DONE,
    input wire logic        BREAK_IRQ,
    input wire logic        POST_RETURN_MASK
);
    // ======================================================================
    // One domain, so one clock and one reset for all
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    // ======================================================================
    // Break request: only a bus cycle or a status write moves it
    property p_irq_rise; $rose(BREAK_IRQ) |-> $past(CPU_CYC_VALID) || $rose(S_AXI_BVALID);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_irq_fall; $fell(BREAK_IRQ) |-> $rose(S_AXI_BVALID); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    property p_status_irq; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 4'h4
        |=> (S_AXI_RDATA[7] && S_AXI_RDATA[6]) == $past(BREAK_IRQ); endproperty
    a_status_irq: assert property (p_status_irq) else $error("irq differs from status");
    property p_status_rsvd; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 4'h4
        |=> S_AXI_RDATA[5:0] == 6'h3F; endproperty
    a_status_rsvd: assert property (p_status_rsvd) else $error("reserved bits not one");

    // ======================================================================
    // Post-return masking window
    property p_mask_set; $rose(POST_RETURN_MASK) |-> $past(CPU_RETURN_DONE); endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask rose without return");
    property p_mask_fall; $fell(POST_RETURN_MASK) |-> $past(CPU_INSN_DONE)
        || $past(CPU_INSN_DONE, 2);
    endproperty
    a_mask_fall: assert property (p_mask_fall) else $error("mask fell without retire");
    property p_mask_hold; POST_RETURN_MASK && !CPU_INSN_DONE && !$past(CPU_INSN_DONE)
        |=> POST_RETURN_MASK; endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask dropped early");

    // ======================================================================
    // Read channel timing of the register port
    property p_rd_answer; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_ar_block; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_ar_block: assert property (p_ar_block) else $error("address taken while answer pending");
    property p_rd_drop; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
    a_rd_drop: assert property (p_rd_drop) else $error("read answer not released");
endmodule

bind abc_top abc_props u_props (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_BVALID(S_AXI_BVALID), .CPU_CYC_VALID(CPU_CYC_VALID),
    .CPU_RETURN_DONE(CPU_RETURN_DONE), .CPU_INSN_DONE(CPU_INSN_DONE), .BREAK_IRQ(BREAK_IRQ),
    .POST_RETURN_MASK(POST_RETURN_MASK)
);

// ===== verif/tb_top.sv
// Self-checking bench for the address break comparator
`timescale 1ns/1ps
module tb_top;
    // ======================================================================
    // Signals and bookkeeping
    logic                clk, rstn, awvalid, wvalid, bready, arvalid, rready, e;
    logic                awready, wready, bvalid, arready, rvalid, irq, pmask;
    logic                ret_done, insn_done;
    logic [3:0]          awaddr, araddr, wstrb;
    logic [31:0]         wdata, rdata, seed;
    logic [1:0]          bresp, rresp;
    logic [7:0]          c;
    logic [15:0]         ba, bd;
    abc_pkg::abc_cycle_t cyc, y;
    logic [33:0]         exp_r[$];
    logic [1:0]          exp_b[$];
    int                  n_mismatch, checks;

    abc_top dut (
        .REF_CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .CPU_CYC_VALID(cyc.valid), .CPU_CYC_FETCH(cyc.fetch), .CPU_CYC_WRITE(cyc.write),
        .CPU_CYC_WORD(cyc.word), .CPU_CYC_IO8(cyc.io8), .CPU_ADDR(cyc.addr),
        .CPU_DATA(cyc.data), .CPU_RETURN_DONE(ret_done), .CPU_INSN_DONE(insn_done),
        .BREAK_IRQ(irq), .POST_RETURN_MASK(pmask)
    );
    abc_cpu cpu (.clk(clk), .cyc(cyc), .ret_done(ret_done), .insn_done(insn_done));

    // ======================================================================
    // Helpers
    task automatic chk(input logic [33:0] got, input logic [33:0] want);
        checks++;
        if (got !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Reference matcher; 8-bit space words are judged as two byte cycles
    function automatic logic hit(input logic [7:0] k, input logic [15:0] a, b,
                                 input abc_pkg::abc_cycle_t v);
        abc_pkg::abc_cycle_t u;
        logic [15:0]         m;
        logic                ok;
        u = v;
        if (v.word && v.io8) begin
            u.word = 1'b0;
            u.data = {v.data[15:8], ~v.data[15:8]};
            ok     = hit(k, a, b, u);
            u.addr = v.addr + 16'h0001;
            u.data = {v.data[7:0], ~v.data[7:0]};
            return ok || hit(k, a, b, u);
        end
        m = 16'hFFFF << (4 * k[3:2]);
        case (k[6:5])
            2'b00: ok = v.fetch;
            2'b01: ok = !v.fetch && !v.write;
            2'b10: ok = !v.fetch && v.write;
            default: ok = !v.fetch;
        endcase
        ok = ok && ((v.addr & m) == (a & m));
        case (k[1:0])
            2'b01: ok = ok && v.word && v.addr[0] && v.data[7:0] == b[7:0];
            2'b10: ok = ok && !(v.word && v.addr[0]) && v.data[15:8] == b[15:8];
            2'b11: ok = ok && v.data == b;
            default: ok = ok;
        endcase
        return ok;
    endfunction

    // Register bus master; bus waits end only through the run ceiling
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r = abc_pkg::RESP_OKAY);
        @(posedge clk);
        exp_b.push_back(r);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] r = abc_pkg::RESP_OKAY);
        @(posedge clk);
        exp_r.push_back({r, d});
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
    endtask

    task automatic complete_run();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ======================================================================
    // Clock, ceiling and response monitor
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Ceiling well above the roughly 1800 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end

    // Oldest note is compared whenever a response is taken
    always @(posedge clk) begin
        if (rvalid && rready)
            chk({rresp, rdata}, exp_r.pop_front());
        if (bvalid && bready)
            chk(bresp, exp_b.pop_front());
    end

    // ======================================================================
    // Main sequence
    initial begin
        {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wstrb, wdata} = '0;
        seed = 32'h0000_3BA7;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(4'h0, 32'h0000_0080);
        rd(4'h4, 32'h0000_003F);
        rd(4'h8, 32'h0000_FFFF);
        rd(4'h2, 32'h0000_0000, abc_pkg::RESP_SLVERR);
        wr(4'h2, 32'h0000_00FF, 4'hF, abc_pkg::RESP_SLVERR);
        wr(4'h8, 32'h0000_12AB, 4'h1);
        wr(4'h8, 32'h0000_CD00, 4'h2);
        rd(4'h8, 32'h0000_CDAB);
        wr(4'h4, 32'h0000_0040, 4'hF);
        // Every cycle and data select code, address select 000 to 011 only, random break values and bus cycles
        for (int i = 0; i < 64; i++) begin
            seed = xs(seed);
            {bd, ba} = seed;
            seed = xs(seed);
            c = {1'b1, i[1:0], 1'b0, i[3:2], (i[1:0] == 2'b00) ? 2'b00 : i[5:4]};
            y = '{1'b1, (i[1:0] == 2'b00) ^ (seed[2:0] == 3'h0), seed[3], seed[6], seed[7],
                  seed[4] ? ba ^ {4'h0, seed[27:16]} : ba, bd ^ {8'h0, {8{seed[5]}}}};
            e = hit(c, ba, bd, y);
            wr(4'h0, {24'h0, c}, 4'hF);
            wr(4'h8, {16'h0, ba}, 4'h3);
            wr(4'hC, {16'h0, bd}, 4'h3);
            cpu.access(y);
            @(posedge clk);
            chk(irq, e);
            wr(4'h4, 32'h0000_0040, 4'hF);
            rd(4'h4, {24'h0, e, 7'h7F});
            wr(4'h4, 32'h0000_0040, 4'hF);
            chk(irq, 1'b0);
        end
        // Enable gating with the flag held
        y = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h2468, 16'h0000};
        wr(4'h0, 32'h0000_0080, 4'hF);
        wr(4'h8, 32'h0000_2468, 4'h3);
        cpu.access(y);
        wr(4'h4, 32'h0000_0080, 4'hF);
        chk(irq, 1'b0);
        rd(4'h4, 32'h0000_00BF);
        wr(4'h4, 32'h0000_00C0, 4'hF);
        chk(irq, 1'b1);
        // Post-return masking, off then on
        cpu.retire(1'b1);
        @(posedge clk);
        chk(pmask, 1'b0);
        wr(4'h0, 32'h0000_0000, 4'hF);
        cpu.retire(1'b1);
        repeat (3) @(posedge clk);
        chk(pmask, 1'b1);
        cpu.retire(1'b0);
        repeat (2) @(posedge clk);
        chk(pmask, 1'b0);
        complete_run();
    end
endmodule
